/* File: src/twr_master_rx.sv */
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "twr_defs.svh"

// How it works
// - flag, start, enable written as one: wait for free bus, then START.
// - after START the flag rises with status 08.
// - direction bit of the first address picks transmit or receive mode.
// - after read address and its ack bit, flag rises with 38, 40 or 48.
// - in 40, flag clear receives a byte, answering ack per ack enable.
// - in 48, start gives repeated START, stop gives STOP, both give STOP then START.
// - in 50, flag clear receives another byte, ack per ack enable.
// - in 58, flag clear gives repeated START, STOP, or STOP then START.
// - in 38, flag clear releases bus, or START once free when start set.
// - in 10, loaded address is sent; its direction bit picks the mode.
// - received byte is in the data register when the flag rises.
// - writing one clears the flag; without enable the bus machine stays idle with pins released.
// - status codes compare with prescaler bits masked off.
// - control bits: flag, ack, start, stop, collision, enable, reserved, irq enable.
// - data write while flag is low is dropped and sets write collision.
module twr_master_rx
    import twr_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // two-wire pins
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // flag level for an outside interrupt controller
    output logic             job_done_flag
);

    twr_regs_t q, d;

    logic wr_acc;
    logic tick;
    logic scl_rise;
    logic sda_fall_hi;
    logic sda_rise_hi;

    // a write lands on the edge where the master sees pready high
    assign wr_acc = psel && penable && pwrite && q.pready;
    assign tick   = (q.tick_cnt == 8'h00);
    assign scl_rise    = q.scl_s2 && !q.scl_prev;
    assign sda_fall_hi = q.scl_s2 && q.scl_prev && q.sda_prev && !q.sda_s2;
    assign sda_rise_hi = q.scl_s2 && q.scl_prev && !q.sda_prev && q.sda_s2;

    always_comb begin
        d = q;
        d.scl_s1   = scl_in;
        d.scl_s2   = q.scl_s1;
        d.sda_s1   = sda_in;
        d.sda_s2   = q.sda_s1;
        d.scl_prev = q.scl_s2;
        d.sda_prev = q.sda_s2;
        d.pready   = 1'b0;
        d.pslverr  = 1'b0;

        // bus busy tracking from seen START and STOP
        if (sda_fall_hi) begin
            d.busy = 1'b1;
        end else if (sda_rise_hi) begin
            d.busy = 1'b0;
        end

        // quarter-bit divider; a slave stretching the clock is waited out in BIT_HIGH
        if (tick) begin
            d.tick_cnt = q.div;
        end else begin
            d.tick_cnt = q.tick_cnt - 8'h01;
        end

        // apb: one wait state, every access answered, unmapped reads give zero
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            if (paddr == `TWR_ADDR_CTRL) begin
                d.prdata[7:0] = q.ctrl & 8'hFD;
            end else if (paddr == `TWR_ADDR_STATUS) begin
                d.prdata[7:0] = q.status;
            end else if (paddr == `TWR_ADDR_DATA) begin
                d.prdata[7:0] = q.data;
            end else if (paddr == `TWR_ADDR_DIV) begin
                d.prdata[7:0] = q.div;
            end else begin
                d.pslverr = 1'b1;
            end
        end
        if (wr_acc) begin
            if (paddr == `TWR_ADDR_CTRL) begin
                d.ctrl[`TWR_CTL_ACK] = pwdata[`TWR_CTL_ACK];
                d.ctrl[`TWR_CTL_STA] = pwdata[`TWR_CTL_STA];
                d.ctrl[`TWR_CTL_STO] = pwdata[`TWR_CTL_STO] | q.ctrl[`TWR_CTL_STO];
                d.ctrl[`TWR_CTL_EN]  = pwdata[`TWR_CTL_EN];
                d.ctrl[`TWR_CTL_IE]  = pwdata[`TWR_CTL_IE];
                if (pwdata[`TWR_CTL_FLAG]) begin
                    d.ctrl[`TWR_CTL_FLAG] = 1'b0;
                    d.ctrl[`TWR_CTL_WCOL] = 1'b0;
                end
            end else if (paddr == `TWR_ADDR_STATUS) begin
                d.status[1:0] = pwdata[1:0];
            end else if (paddr == `TWR_ADDR_DATA) begin
                if (q.ctrl[`TWR_CTL_FLAG]) begin
                    d.data = pwdata[7:0];
                end else begin
                    d.ctrl[`TWR_CTL_WCOL] = 1'b1;
                end
            end else if (paddr == `TWR_ADDR_DIV) begin
                d.div = pwdata[7:0];
            end
            // unmapped writes are dropped; their error went out with pready
        end

        if (!q.ctrl[`TWR_CTL_EN]) begin
            // disabled: pins released, machine idle
            d.state  = TWR_IDLE;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.status[7:3] = 5'b11111;
        end else if (tick) begin
            unique case (q.state)
                TWR_IDLE: begin
                    d.scl_oe = 1'b0;
                    d.sda_oe = 1'b0;
                    if (!q.ctrl[`TWR_CTL_FLAG] && q.ctrl[`TWR_CTL_STA]) begin
                        d.state = TWR_WAIT_FREE;
                    end
                end
                TWR_WAIT_FREE: begin
                    if (!q.busy && q.scl_s2 && q.sda_s2) begin
                        d.state = TWR_START_A;
                    end
                end
                TWR_START_A: begin
                    d.sda_oe = 1'b1;
                    d.state  = TWR_START_B;
                end
                TWR_START_B: begin
                    // start done: hold clock low and report
                    d.scl_oe = 1'b1;
                    d.ctrl[`TWR_CTL_STA]  = 1'b0;
                    d.ctrl[`TWR_CTL_FLAG] = 1'b1;
                    d.status[7:3] = 5'(q.rstart ? `TWR_ST_RSTART >> 3
                                                : `TWR_ST_START >> 3);
                    d.phase = TWR_PH_ADDR;
                    d.state = TWR_HOLD;
                end
                TWR_BIT_LOW: begin
                    d.scl_oe = 1'b1;
                    if (q.bit_cnt == 4'd8) begin
                        // ninth slot: ack from us when receiving data with ack enabled, else released
                        d.sda_oe = (q.phase == TWR_PH_DATA) && q.rx_mode && q.ack_bit;
                    end else begin
                        d.sda_oe = q.rx_mode && (q.phase == TWR_PH_DATA) ? 1'b0
                                 : !q.shreg[7];
                    end
                    d.state = TWR_BIT_HIGH;
                end
                TWR_BIT_HIGH: begin
                    d.scl_oe = 1'b0;
                    if (scl_rise || q.scl_s2) begin
                        d.state = TWR_BIT_DONE;
                    end
                end
                TWR_BIT_DONE: begin
                    d.scl_oe = 1'b1;
                    d.state  = TWR_BIT_LOW;
                    if (q.bit_cnt == 4'd8) begin
                        d.ctrl[`TWR_CTL_FLAG] = 1'b1;
                        d.sda_oe = 1'b0;
                        d.state  = TWR_HOLD;
                        if (q.phase == TWR_PH_ADDR) begin
                            d.rx_mode = q.shreg[0];
                            d.status[7:3] = 5'(q.shreg[0]
                                ? (q.sda_s2 ? `TWR_ST_AR_NACK >> 3 : `TWR_ST_AR_ACK >> 3)
                                : (q.sda_s2 ? `TWR_ST_MT_NACK >> 3 : `TWR_ST_MT_ACK >> 3));
                            d.phase = TWR_PH_DATA;
                        end else begin
                            d.data = q.shreg;
                            d.status[7:3] = 5'(q.ack_bit ? `TWR_ST_RX_ACK >> 3
                                                         : `TWR_ST_RX_NACK >> 3);
                        end
                    end else if (!q.rx_mode || q.phase == TWR_PH_ADDR) begin
                        // arbitration: we sent one but the line reads zero
                        if (q.shreg[7] && !q.sda_s2) begin
                            d.scl_oe = 1'b0;
                            d.sda_oe = 1'b0;
                            d.ctrl[`TWR_CTL_FLAG] = 1'b1;
                            d.status[7:3] = 5'(`TWR_ST_ARB >> 3);
                            d.state = TWR_HOLD;
                        end
                        d.shreg   = {q.shreg[6:0], q.sda_s2};
                        d.bit_cnt = q.bit_cnt + 4'd1;
                    end else begin
                        d.shreg   = {q.shreg[6:0], q.sda_s2};
                        d.bit_cnt = q.bit_cnt + 4'd1;
                    end
                end
                TWR_HOLD: begin
                    d.scl_oe = (q.status[7:3] != 5'(`TWR_ST_ARB >> 3));
                    if (!q.ctrl[`TWR_CTL_FLAG]) begin
                        d.bit_cnt = 4'd0;
                        d.rstart  = 1'b0;
                        if (q.status[7:3] == 5'(`TWR_ST_ARB >> 3)) begin
                            // lost the bus: release, or start again when free
                            d.scl_oe = 1'b0;
                            d.sda_oe = 1'b0;
                            d.state  = q.ctrl[`TWR_CTL_STA] ? TWR_WAIT_FREE : TWR_IDLE;
                        end else if (q.ctrl[`TWR_CTL_STO]) begin
                            d.restart_after = q.ctrl[`TWR_CTL_STA];
                            d.sda_oe = 1'b1;
                            d.state  = TWR_STOP_A;
                        end else if (q.ctrl[`TWR_CTL_STA]) begin
                            d.rstart = 1'b1;
                            d.sda_oe = 1'b0;
                            d.state  = TWR_STOP_B;
                        end else if (q.phase == TWR_PH_ADDR) begin
                            d.shreg = q.data;
                            d.state = TWR_BIT_LOW;
                        end else begin
                            d.shreg   = 8'hFF;
                            d.ack_bit = q.ctrl[`TWR_CTL_ACK];
                            d.state   = TWR_BIT_LOW;
                        end
                    end
                end
                TWR_STOP_A: begin
                    d.scl_oe = 1'b0;
                    d.state  = TWR_STOP_B;
                end
                TWR_STOP_B: begin
                    // clock released; repeated start keeps sda high here
                    d.scl_oe = 1'b0;
                    if (q.scl_s2) begin
                        d.sda_oe = 1'b0;
                        d.state  = q.rstart ? TWR_START_A : TWR_STOP_C;
                    end
                end
                TWR_STOP_C: begin
                    d.ctrl[`TWR_CTL_STO] = 1'b0;
                    d.status[7:3] = 5'b11111;
                    d.state = q.restart_after ? TWR_WAIT_FREE : TWR_IDLE;
                    d.ctrl[`TWR_CTL_STA] = q.restart_after;
                    d.restart_after = 1'b0;
                end
                default: d.state = TWR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.ctrl     <= `TWR_RST_CTRL;
            q.status   <= `TWR_ST_IDLE;
            q.data     <= `TWR_RST_DATA;
            q.div      <= `TWR_RST_DIV;
            q.state    <= TWR_IDLE;
            q.phase    <= TWR_PH_ADDR;
            q.scl_s1   <= 1'b1;
            q.scl_s2   <= 1'b1;
            q.sda_s1   <= 1'b1;
            q.sda_s2   <= 1'b1;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata        = q.prdata;
    assign pready        = q.pready;
    assign pslverr       = q.pslverr;
    assign scl_out       = 1'b0;
    assign scl_oe        = q.scl_oe;
    assign sda_out       = 1'b0;
    assign sda_oe        = q.sda_oe;
    assign job_done_flag = q.ctrl[`TWR_CTL_FLAG];

    // while the flag is held, the clock line is pulled low unless arbitration was lost (38)
    a_hold_clock_low: assert property (@(posedge clk) disable iff (rst)
        (q.state == TWR_HOLD && q.ctrl[`TWR_CTL_FLAG] && q.status[7:3] != 5'b00111)
        ##1 (q.state == TWR_HOLD) |-> q.scl_oe)
        else $error("clock line not held while flag set");

    a_start_status: assert property (@(posedge clk) disable iff (rst)
        (q.state == TWR_START_B && tick && q.ctrl[`TWR_CTL_EN] && !q.rstart)
        |=> q.ctrl[`TWR_CTL_FLAG] && q.status[7:3] == 5'b00001)
        else $error("start not reported as 08");

    a_wcol_set: assert property (@(posedge clk) disable iff (rst)
        (wr_acc && paddr == `TWR_ADDR_DATA && !q.ctrl[`TWR_CTL_FLAG])
        |=> q.ctrl[`TWR_CTL_WCOL] && $stable(q.data))
        else $error("collision write not discarded");

    a_flag_clear: assert property (@(posedge clk) disable iff (rst)
        (wr_acc && paddr == `TWR_ADDR_CTRL && pwdata[7] && !(tick && q.state == TWR_BIT_DONE))
        |=> !q.ctrl[`TWR_CTL_FLAG] || $past(q.state) == TWR_START_B)
        else $error("flag not cleared by writing one");

    a_disable_idle: assert property (@(posedge clk) disable iff (rst)
        !q.ctrl[`TWR_CTL_EN] |=> q.state == TWR_IDLE && !q.sda_oe)
        else $error("disabled unit still active");

    a_apb_answer: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !q.pready) |=> q.pready ##1 !q.pready)
        else $error("apb answer not one cycle");

    a_rx_data_valid: assert property (@(posedge clk) disable iff (rst)
        $rose(q.ctrl[`TWR_CTL_FLAG]) && q.status[7:4] == 4'b0101
        |-> q.data == $past(q.shreg))
        else $error("received byte not in data register");

    a_stop_clears: assert property (@(posedge clk) disable iff (rst)
        (q.state == TWR_STOP_C && tick && q.ctrl[`TWR_CTL_EN])
        |=> !q.ctrl[`TWR_CTL_STO])
        else $error("stop request not cleared");

    // while a data byte comes in, the data line belongs to the slave
    a_rx_release: assert property (@(posedge clk) disable iff (rst)
        (q.state == TWR_BIT_HIGH && q.rx_mode && q.phase == TWR_PH_DATA && q.bit_cnt != 4'd8)
        |-> !q.sda_oe)
        else $error("data line driven during a received bit");

endmodule
`default_nettype wire

/* File: src/twr_defs.svh */
`ifndef TWR_DEFS_SVH
`define TWR_DEFS_SVH

// register byte addresses on the apb slave
`define TWR_ADDR_CTRL    12'h000
`define TWR_ADDR_STATUS  12'h004
`define TWR_ADDR_DATA    12'h008
`define TWR_ADDR_DIV     12'h00C

// control register field positions
`define TWR_CTL_FLAG     7
`define TWR_CTL_ACK      6
`define TWR_CTL_STA      5
`define TWR_CTL_STO      4
`define TWR_CTL_WCOL     3
`define TWR_CTL_EN       2
`define TWR_CTL_IE       0

// status codes, upper five bits of the status register
`define TWR_ST_START     8'h08
`define TWR_ST_RSTART    8'h10
`define TWR_ST_MT_ACK    8'h18
`define TWR_ST_MT_NACK   8'h20
`define TWR_ST_ARB       8'h38
`define TWR_ST_AR_ACK    8'h40
`define TWR_ST_AR_NACK   8'h48
`define TWR_ST_RX_ACK    8'h50
`define TWR_ST_RX_NACK   8'h58
`define TWR_ST_IDLE      8'hF8

// reset values
`define TWR_RST_CTRL     8'h00
`define TWR_RST_DATA     8'hFF
`define TWR_RST_DIV      8'h4E

`endif

/* File: src/twr_pkg.sv */
package twr_pkg;

    typedef enum logic [3:0] {
        TWR_IDLE,
        TWR_WAIT_FREE,
        TWR_START_A,
        TWR_START_B,
        TWR_BIT_LOW,
        TWR_BIT_HIGH,
        TWR_BIT_DONE,
        TWR_HOLD,
        TWR_STOP_A,
        TWR_STOP_B,
        TWR_STOP_C
    } twr_state_t;

    typedef enum logic [1:0] {
        TWR_PH_ADDR,
        TWR_PH_DATA
    } twr_phase_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] data;
        logic [7:0] shreg;
        logic [7:0] div;
        logic [7:0] tick_cnt;
        logic [3:0] bit_cnt;
        twr_state_t state;
        twr_phase_t phase;
        logic       rx_mode;
        logic       ack_bit;
        logic       busy;
        logic       rstart;
        logic       restart_after;
        logic       scl_oe;
        logic       sda_oe;
        logic       scl_s1;
        logic       scl_s2;
        logic       sda_s1;
        logic       sda_s2;
        logic       scl_prev;
        logic       sda_prev;
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
    } twr_regs_t;

endpackage

/* File: test/twr_slave_tx.sv */
`timescale 1ns/1ps
`default_nettype none

// slave transmitter: acks its read address, then sends BASE, BASE+1, ...
// until the master answers not ack; starts and restarts are both caught
// by the start detector, since a stop alone needs no reaction here
module twr_slave_tx #(
    parameter logic [6:0] ADDR = 7'h2A,
    parameter logic [7:0] BASE = 8'h96
) (
    // open-drain bus, already resolved
    input  wire logic scl,
    input  wire logic sda,
    // high pulls sda low
    output logic      sda_pull
);
    logic [7:0] sh;
    logic [7:0] tx;
    logic       hit;
    logic       last;
    int         i;
    int         k;

    initial begin
        sda_pull = 1'b0;
        sh       = 8'h00;
        k        = 0;
        forever begin
            @(negedge sda iff scl === 1'b1);
            for (i = 0; i < 8; i++) begin
                @(posedge scl);
                sh = {sh[6:0], sda};
            end
            @(negedge scl);
            hit      = (sh[7:1] == ADDR) && sh[0];
            sda_pull = hit;
            @(negedge scl);
            sda_pull = 1'b0;
            last     = ~hit;
            while (!last) begin
                tx = BASE + 8'(k);
                k++;
                for (i = 7; i >= 0; i--) begin
                    sda_pull = ~tx[i];
                    @(negedge scl);
                end
                // released for the master's answer bit
                sda_pull = 1'b0;
                @(posedge scl);
                last = sda;
                @(negedge scl);
            end
        end
    end
endmodule

`default_nettype wire

/* File: test/two_wire_master_receiver_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "twr_defs.svh"

module two_wire_master_receiver_test
    import twr_pkg::*;
;
    localparam logic [6:0]  SLV   = 7'h2A;
    localparam logic [7:0]  BASE  = 8'h96;
    localparam logic [31:0] FULL  = 32'hFFFF_FFFF;
    localparam logic [31:0] SMASK = 32'h0000_00F8;
    localparam int          LIMIT = 20000;

    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl_oe;
    logic        sda_oe;
    logic        s_pull;
    logic        job_done_flag;
    wire logic   scl_w;
    wire logic   sda_w;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;
    logic [31:0] q;
    logic        e;

    // pull-ups on both lines
    assign scl_w = ~scl_oe;
    assign sda_w = ~(sda_oe | s_pull);

    twr_master_rx uut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .job_done_flag(job_done_flag)
    );

    twr_slave_tx #(.ADDR(SLV), .BASE(BASE)) slv (
        .scl(scl_w), .sda(sda_w), .sda_pull(s_pull)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic finish_test();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask

    // a trailing idle edge keeps the next request off this time step
    task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] wq;
        logic        we;
        apb(1'b1, a, {24'h00_0000, d}, wq, we);
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x,
                      input logic [31:0] m);
        logic [31:0] rq;
        logic        re;
        apb(1'b0, a, 32'h0000_0000, rq, re);
        chk(nm, x & m, rq & m);
    endtask

    // write control, wait for the flag, compare the masked status code
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        wr(`TWR_ADDR_CTRL, c);
        while (job_done_flag !== 1'b1) @(posedge clk);
        rd("status", `TWR_ADDR_STATUS, {24'h00_0000, st}, SMASK);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd("ctrl rst", `TWR_ADDR_CTRL, 32'h0000_0000, FULL);
        rd("status rst", `TWR_ADDR_STATUS, 32'h0000_00F8, FULL);
        rd("data rst", `TWR_ADDR_DATA, 32'h0000_00FF, FULL);
        rd("div rst", `TWR_ADDR_DIV, 32'h0000_004E, FULL);
        wr(`TWR_ADDR_STATUS, 8'h03);
        rd("prescaler", `TWR_ADDR_STATUS, 32'h0000_00FB, FULL);
        wr(`TWR_ADDR_CTRL, 8'h43);
        rd("ctrl bits", `TWR_ADDR_CTRL, 32'h0000_0041, FULL);
        apb(1'b0, 12'h010, 32'h0000_0000, q, e);
        chk("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
        chk("unmapped data", 32'h0000_0000, q);
        wr(`TWR_ADDR_DATA, 8'h5A);
        rd("wcol data", `TWR_ADDR_DATA, 32'h0000_00FF, FULL);
        rd("wcol bit", `TWR_ADDR_CTRL, 32'h0000_0008, 32'h0000_0008);
        // start asked for without enable: nothing may move
        wr(`TWR_ADDR_CTRL, 8'hA0);
        repeat (200) @(posedge clk);
        chk("idle pins", 32'h0000_0000, {29'h0000_0000, job_done_flag, scl_oe, sda_oe});
        wr(`TWR_ADDR_DIV, 8'h01);
        step(8'hA4, `TWR_ST_START);
        repeat (60) @(posedge clk);
        chk("scl held", 32'h0000_0001, {31'h0000_0000, scl_oe});
        wr(`TWR_ADDR_DATA, {SLV, 1'b1});
        step(8'h84, `TWR_ST_AR_ACK);
        step(8'hC4, `TWR_ST_RX_ACK);
        rd("byte 0", `TWR_ADDR_DATA, {24'h00_0000, BASE}, FULL);
        step(8'h84, `TWR_ST_RX_NACK);
        rd("byte 1", `TWR_ADDR_DATA, {24'h00_0000, BASE + 8'h01}, FULL);
        step(8'hB4, `TWR_ST_START);
        rd("stop cleared", `TWR_ADDR_CTRL, 32'h0000_0000, 32'h0000_0010);
        wr(`TWR_ADDR_DATA, 8'hAB);
        step(8'h84, `TWR_ST_AR_NACK);
        step(8'hA4, `TWR_ST_RSTART);
        wr(`TWR_ADDR_DATA, {SLV, 1'b1});
        step(8'h84, `TWR_ST_AR_ACK);
        step(8'hC4, `TWR_ST_RX_ACK);
        rd("byte 2", `TWR_ADDR_DATA, {24'h00_0000, BASE + 8'h02}, FULL);
        step(8'h84, `TWR_ST_RX_NACK);
        rd("byte 3", `TWR_ADDR_DATA, {24'h00_0000, BASE + 8'h03}, FULL);
        wr(`TWR_ADDR_CTRL, 8'h94);
        repeat (100) @(posedge clk);
        rd("after stop", `TWR_ADDR_CTRL, 32'h0000_0004, FULL);
        chk("lines free", 32'h0000_0003, {30'h0000_0000, scl_w, sda_w});
        finish_test();
    end
endmodule

`default_nettype wire
